//--- rtl/dcsb_pkg.sv
// Package: register map, field layout and types of the config/scratch block
`default_nettype none
package dcsb_pkg;

   // Register offsets on the internal register port
   localparam logic [7:0] OFS_DEV_OP_SETUP  = 8'h25;
   localparam logic [7:0] OFS_HOST_LINK     = 8'h26;
   localparam logic [7:0] OFS_SCRATCH_PTR   = 8'h2b;
   localparam logic [7:0] OFS_SCRATCH_WORD  = 8'h2c;
   localparam logic [7:0] OFS_SHARED_CODE   = 8'h50;

   // Register addresses when reached over the power-management bus
   localparam logic [7:0] PMB_PAGE_CFG      = 8'hff;
   localparam logic [7:0] PMB_DEV_OP_SETUP  = 8'he9;
   localparam logic [7:0] PMB_SCRATCH_PTR   = 8'hef;
   localparam logic [7:0] PMB_SCRATCH_WORD  = 8'hf0;
   localparam logic [7:0] PMB_SHARED_CODE   = 8'hf1;

   // Field positions
   localparam int LOW_POWER_BIT   = 13;
   localparam int PROT_LSB        = 8;
   localparam int TIMEOUT_EN_BIT  = 12;
   localparam int PMBUS_EN_BIT    = 8;
   localparam int QUICK_RB_BIT    = 2;
   localparam int RB_GPIO_BIT     = 0;
   localparam int CODE_LSB        = 4;

   // Writable masks: bits that store a value; reset word of the control registers
   localparam logic [15:0] DEV_OP_MASK    = 16'hffff;
   localparam logic [15:0] HOST_LINK_MASK = 16'h1105;
   localparam logic [15:0] PTR_MASK       = 16'h00ff;
   localparam logic [15:0] CODE_MASK      = 16'hfff0;
   localparam logic [15:0] RESET_WORD     = 16'h0000;

   // Gpio input function code that arms the protect input
   localparam logic [3:0] GPI_PROTECT = 4'h5;
   // Current mode uses the top 8 of the 12 code bits
   localparam logic [11:0] CUR_KEEP   = 12'hff0;

   // Protect actions
   typedef enum logic [1:0] {
      PROT_HIZ       = 2'b00,
      PROT_NVM_JUMP  = 2'b01,
      PROT_SLEW_LOW  = 2'b10,
      PROT_SLEW_HIGH = 2'b11
   } dcsb_prot_type;

   // Protect sequencer states, Gray along the usual path
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_MOVE = 2'b01,
      PS_WAIT = 2'b11,
      PS_HIZ  = 2'b10
   } dcsb_pstate_type;

   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       pmbus;
      logic [7:0] page;
      logic [7:0] addr;
      logic [15:0] wdata;
   } dcsb_req_type;

   // Order to the output stage after a protect event
   typedef struct packed {
      logic       hiz;
      logic       jump_nvm;
      logic       slew_low;
      logic       slew_high;
   } dcsb_prot_cmd_type;

endpackage
`default_nettype wire

//--- rtl/dcsb_sram.sv
// Scratch memory: one write port, registered read data
`timescale 1ns/1ns
`default_nettype none
module dcsb_sram #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input  wire logic          mclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   // Storage array, no reset: contents are undefined at power-up
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Write and registered read
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

//--- rtl/dcsb_cfg_regs.sv
// Configuration, scratch-memory and shared-code register group
`timescale 1ns/1ns
`default_nettype none
module dcsb_cfg_regs
   import dcsb_pkg::*;
#(
   parameter int NCH  = 2,
   parameter int AW   = 8,
   parameter int CW   = 12
) (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire dcsb_req_type       req,
   output logic      [15:0]        rdata,
   output logic                    rvalid,
   input  wire logic               gpio_in,
   input  wire logic [3:0]         gpi_func,
   input  wire logic               gpi_en,
   input  wire logic               slew_done,
   input  wire logic [NCH-1:0]     channel_shared_code_join,
   input  wire logic [NCH-1:0]     current_output_mode,
   output logic      [NCH-1:0]     shared_load,
   output logic      [CW-1:0]      shared_code_value,
   output dcsb_prot_cmd_type       prot_cmd,
   output logic                    low_power_select_bit,
   output logic                    i2c_timeout_en,
   output logic                    pmbus_en,
   output logic                    quick_readback_drive,
   output logic                    readback_on_gpio
);

   ///////////////////////////////////////////////////////////////////////
   // Registers
   logic [15:0]     dev_op_ff;     // Device operating setup
   logic [15:0]     host_link_ff;  // Host link setup
   logic [AW-1:0]   ptr_ff;        // Scratch pointer
   logic [15:0]     code_ff;       // Shared code
   logic            gpio_d_ff;     // Previous gpio level
   dcsb_pstate_type pstate_ff;     // Protect sequencer
   dcsb_pstate_type nxt_pstate;
   dcsb_prot_cmd_type nxt_prot_cmd;
   logic [15:0]     mem_rdata;     // Registered memory word
   logic [15:0]     nxt_rdata;
   logic            rd_mem_ff;     // Read of the data port pending

   ///////////////////////////////////////////////////////////////////////
   // Address decode; PMBus form only counts while PMBus is on
   wire pm_ok   = req.pmbus & pmbus_en & (req.page == PMB_PAGE_CFG);
   wire native  = ~req.pmbus;
   wire hit_dev = native ? (req.addr == OFS_DEV_OP_SETUP)
                         : pm_ok & (req.addr == PMB_DEV_OP_SETUP);
   wire hit_hl  = native & (req.addr == OFS_HOST_LINK);
   wire hit_ptr = native ? (req.addr == OFS_SCRATCH_PTR)
                         : pm_ok & (req.addr == PMB_SCRATCH_PTR);
   wire hit_wd  = native ? (req.addr == OFS_SCRATCH_WORD)
                         : pm_ok & (req.addr == PMB_SCRATCH_WORD);
   wire hit_sc  = native ? (req.addr == OFS_SHARED_CODE)
                         : pm_ok & (req.addr == PMB_SHARED_CODE);

   // Data-port write strobe to the memory
   wire mem_we  = req.wr & hit_wd;

   ///////////////////////////////////////////////////////////////////////
   // Control register writes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dev_op_ff    <= RESET_WORD;
         host_link_ff <= RESET_WORD;
         code_ff      <= RESET_WORD;
      end else if (req.wr) begin
         if (hit_dev) begin
            dev_op_ff <= req.wdata & DEV_OP_MASK;
         end
         if (hit_hl) begin
            host_link_ff <= req.wdata & HOST_LINK_MASK;
         end
         if (hit_sc) begin
            code_ff <= req.wdata & CODE_MASK;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Pointer: explicit write wins, else bump after a data write
   wire [AW-1:0] ptr_inc = ptr_ff + AW'(1);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ptr_ff <= '0;
      end else if (req.wr & hit_ptr) begin
         ptr_ff <= req.wdata[AW-1:0];
      end else if (mem_we) begin
         ptr_ff <= ptr_inc;
      end
   end

   // Scratch store, read and written at the current pointer
   dcsb_sram #(.AW(AW), .DW(16)) i_dcsb_sram (
      .mclk  (mclk),
      .we    (mem_we),
      .addr  (ptr_ff),
      .wdata (req.wdata),
      .rdata (mem_rdata)
   );

   ///////////////////////////////////////////////////////////////////////
   // Read path: one-cycle answer, memory word one cycle later
   // Memory reads take two cycles because the array output is registered
   always_comb begin
      nxt_rdata = 16'h0000;
      if (hit_dev) begin
         nxt_rdata = dev_op_ff;
      end else if (hit_hl) begin
         nxt_rdata = host_link_ff;
      end else if (hit_ptr) begin
         nxt_rdata = {{(16-AW){1'b0}}, ptr_ff};
      end else if (hit_sc) begin
         nxt_rdata = code_ff;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata     <= 16'h0000;
         rvalid    <= 1'b0;
         rd_mem_ff <= 1'b0;
      end else begin
         rd_mem_ff <= req.rd & hit_wd;
         if (rd_mem_ff) begin
            rdata  <= mem_rdata;
            rvalid <= 1'b1;
         end else if (req.rd & ~hit_wd) begin
            rdata  <= nxt_rdata;                         // Unmapped reads 0
            rvalid <= 1'b1;
         end else begin
            rvalid <= 1'b0;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Shared code decode per output mode
   wire [CW-1:0] code_raw = code_ff[15:CODE_LSB];
   wire          sc_write = req.wr & hit_sc;

   // One lane per channel; only joined channels load
   genvar g;
   logic [NCH-1:0] nxt_load;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         assign nxt_load[g] = sc_write & channel_shared_code_join[g];
      end
   endgenerate

   // Mode mask: current mode drops the low four code bits
   wire any_cur = |(current_output_mode & channel_shared_code_join);
   wire [CW-1:0] wcode = req.wdata[15:CODE_LSB];
   wire [CW-1:0] nxt_code = any_cur ? (wcode & CUR_KEEP) : wcode;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shared_load       <= '0;
         shared_code_value <= '0;
      end else begin
         shared_load <= nxt_load;
         if (sc_write) begin
            shared_code_value <= nxt_code;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Protect input: falling edge while armed as protect input
   wire armed   = gpi_en & (gpi_func == GPI_PROTECT);
   wire fall    = gpio_d_ff & ~gpio_in;
   wire trigger = armed & fall;
   wire dcsb_prot_type action =
      dcsb_prot_type'(dev_op_ff[PROT_LSB+1:PROT_LSB]);

   // Sequencer next state; a new trigger is ignored while busy
   always_comb begin
      nxt_pstate   = pstate_ff;
      nxt_prot_cmd = '0;
      case (pstate_ff)
         PS_IDLE: begin
            if (trigger) begin
               case (action)
                  PROT_HIZ: begin
                     nxt_pstate       = PS_HIZ;
                     nxt_prot_cmd.hiz = 1'b1;
                  end
                  PROT_NVM_JUMP: begin
                     nxt_pstate            = PS_MOVE;
                     nxt_prot_cmd.jump_nvm = 1'b1;
                  end
                  PROT_SLEW_LOW: begin
                     nxt_pstate            = PS_MOVE;
                     nxt_prot_cmd.slew_low = 1'b1;
                  end
                  default: begin
                     nxt_pstate             = PS_MOVE;
                     nxt_prot_cmd.slew_high = 1'b1;
                  end
               endcase
            end
         end
         PS_MOVE: begin
            // Jump lands at once; slews wait for the output stage
            nxt_pstate = PS_WAIT;
         end
         PS_WAIT: begin
            if (action == PROT_NVM_JUMP || slew_done) begin
               nxt_pstate       = PS_HIZ;
               nxt_prot_cmd.hiz = 1'b1;
            end
         end
         PS_HIZ: begin
            nxt_pstate       = PS_HIZ;  // Held until reset
            nxt_prot_cmd.hiz = 1'b1;
         end
         default: begin
            nxt_pstate = PS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gpio_d_ff <= 1'b1;
         pstate_ff <= PS_IDLE;
         prot_cmd  <= '0;
      end else begin
         gpio_d_ff <= gpio_in;
         pstate_ff <= nxt_pstate;
         prot_cmd  <= nxt_prot_cmd;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Option outputs, each straight from a flop
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_power_select_bit <= 1'b0;
         i2c_timeout_en       <= 1'b0;
         pmbus_en             <= 1'b0;
         quick_readback_drive <= 1'b0;
         readback_on_gpio     <= 1'b0;
      end else begin
         low_power_select_bit <= dev_op_ff[LOW_POWER_BIT];
         i2c_timeout_en       <= host_link_ff[TIMEOUT_EN_BIT];
         pmbus_en             <= host_link_ff[PMBUS_EN_BIT];
         quick_readback_drive <= host_link_ff[QUICK_RB_BIT];
         readback_on_gpio     <= host_link_ff[RB_GPIO_BIT];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Checks
   AST_PTR_INC: assert property (@(posedge mclk) disable iff (rst)
      mem_we && !(req.wr && hit_ptr) |=> ptr_ff == $past(ptr_ff) + AW'(1))
      else $error("Pointer did not advance after data write");
   AST_PTR_SET: assert property (@(posedge mclk) disable iff (rst)
      req.wr && hit_ptr |=> ptr_ff == $past(req.wdata[AW-1:0]))
      else $error("Pointer write not taken");
   AST_CODE_LOW: assert property (@(posedge mclk) disable iff (rst)
      code_ff[3:0] == 4'h0)
      else $error("Shared code low bits stored");
   // Voltage-mode output must match the stored upper code bits
   AST_CODE_OUT: assert property (@(posedge mclk) disable iff (rst)
      sc_write && !any_cur |=> shared_code_value == code_raw)
      else $error("Shared code output differs from stored code");
   AST_JOIN: assert property (@(posedge mclk) disable iff (rst)
      sc_write |=> shared_load == $past(channel_shared_code_join))
      else $error("Shared load does not follow join bits");
   AST_PMB_EN: assert property (@(posedge mclk) disable iff (rst)
      req.wr && hit_hl ##1 1'b1
      |=> pmbus_en == $past(req.wdata[PMBUS_EN_BIT], 2))
      else $error("PMBus enable out of step");
   AST_RB_GPIO: assert property (@(posedge mclk) disable iff (rst)
      req.wr && hit_hl ##1 1'b1
      |=> readback_on_gpio == $past(req.wdata[RB_GPIO_BIT], 2))
      else $error("Readback drive not following bit 0");
   AST_HIZ_DIRECT: assert property (
      @(posedge mclk) disable iff (rst)
      pstate_ff == PS_IDLE && trigger && action == PROT_HIZ
      |=> prot_cmd.hiz)
      else $error("Hi-Z not entered on action 00");
   // Slew-high order comes in the cycle right after the trigger, without Hi-Z
   AST_SLEW: assert property (@(posedge mclk) disable iff (rst)
      pstate_ff == PS_IDLE && trigger && action == PROT_SLEW_HIGH
      |=> prot_cmd.slew_high && !prot_cmd.hiz)
      else $error("Slew high not issued first");
   AST_NO_HIGH: assert property (@(posedge mclk) disable iff (rst)
      pstate_ff == PS_IDLE && !fall |=> pstate_ff == PS_IDLE)
      else $error("Protect started without falling edge");
   AST_LOWPWR: assert property (@(posedge mclk) disable iff (rst)
      req.wr && hit_dev ##1 1'b1
      |=> low_power_select_bit == $past(req.wdata[LOW_POWER_BIT], 2))
      else $error("Low power bit not passed on");
endmodule
`default_nettype wire

//--- tb/dcsb_host.sv
// Host controller model: issues register requests to the config group
`timescale 1ns/1ns
`default_nettype none
module dcsb_host
   import dcsb_pkg::*;
(
   input  wire logic         mclk,
   output var  dcsb_req_type req,
   input  wire logic  [15:0] rdata,
   input  wire logic         rvalid
);
   //////////////////////////////////////////////////////////////////////////
   // Idle bus from time zero
   initial begin
      req = '0;
   end

   // One write: strobe for one edge, then scramble the released fields
   task automatic wr_reg(input logic pmb, input logic [7:0] pg,
                         input logic [7:0] ad, input logic [15:0] wd);
      @(posedge mclk);
      req.wr    <= 1'b1;
      req.pmbus <= pmb;
      req.page  <= pg;
      req.addr  <= ad;
      req.wdata <= wd;
      @(posedge mclk);
      req.wr    <= 1'b0;
      // Stale values would hide a late sample
      req.addr  <= ~ad;
      req.wdata <= ~wd;
   endtask

   // One read; a missing answer comes back unknown
   task automatic rd_reg(input logic pmb, input logic [7:0] pg,
                         input logic [7:0] ad, output logic [15:0] rd);
      rd = 16'hxxxx;
      @(posedge mclk);
      req.rd    <= 1'b1;
      req.pmbus <= pmb;
      req.page  <= pg;
      req.addr  <= ad;
      @(posedge mclk);
      req.rd    <= 1'b0;
      req.addr  <= ~ad;
      // Bounded wait; also keeps the gap after a data-port read
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         if (rvalid === 1'b1) begin
            rd = rdata;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

//--- tb/dcsb_cfg_regs_test.sv
// Self-checking bench for the config, scratch and shared-code group
`timescale 1ns/1ns
`default_nettype none
module dcsb_cfg_regs_test;
   import dcsb_pkg::*;
   logic              mclk;        // 20 MHz clock
   logic              rst;         // Async reset
   dcsb_req_type      req;         // Register request
   logic       [15:0] rdata;       // Read answer
   logic              rvalid;      // Answer strobe
   logic              gpio_in;     // Gpio pin level
   logic       [3:0]  gpi_func;    // Gpio input function
   logic              gpi_en;      // Gpio input enable
   logic              slew_done;   // Output stage finished
   logic       [1:0]  share_join;  // Channel join bits
   logic       [1:0]  cur_mode;    // Channel current mode
   logic       [1:0]  shared_load; // Load pulses
   logic       [11:0] code;        // Shared code out
   dcsb_prot_cmd_type prot_cmd;    // Protect order
   wire logic  [4:0]  lvl;         // Config level outputs
   logic       [15:0] d;           // Read result
   int                miscompares; // Mismatch count
   int                n_compared;  // Comparison count

   dcsb_cfg_regs #(.NCH(2), .AW(8), .CW(12)) i_dcsb_cfg_regs (
      .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
      .gpio_in(gpio_in), .gpi_func(gpi_func), .gpi_en(gpi_en),
      .slew_done(slew_done), .channel_shared_code_join(share_join),
      .current_output_mode(cur_mode), .shared_load(shared_load),
      .shared_code_value(code), .prot_cmd(prot_cmd),
      .low_power_select_bit(lvl[4]), .i2c_timeout_en(lvl[3]),
      .pmbus_en(lvl[2]), .quick_readback_drive(lvl[1]),
      .readback_on_gpio(lvl[0]));
   dcsb_host i_dcsb_host (.mclk(mclk), .req(req), .rdata(rdata),
      .rvalid(rvalid));

   //////////////////////////////////////////////////////////////////////////
   // Clock source
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Shared comparison
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Short bus helpers, native and power-management forms
   task automatic w(input logic [7:0] a, input logic [15:0] v);
      i_dcsb_host.wr_reg(1'b0, 8'h00, a, v);
   endtask
   task automatic r(input logic [7:0] a, output logic [15:0] v);
      i_dcsb_host.rd_reg(1'b0, 8'h00, a, v);
   endtask
   task automatic pw(input logic [7:0] a, input logic [15:0] v);
      i_dcsb_host.wr_reg(1'b1, PMB_PAGE_CFG, a, v);
   endtask

   // Reset with protect inputs parked
   task automatic do_reset;
      @(posedge mclk);
      rst       <= 1'b1;
      gpio_in   <= 1'b1;
      gpi_en    <= 1'b0;
      slew_done <= 1'b0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // Reset values and an unmapped place
   task automatic t_reset;
      chk({11'h0, lvl}, 16'h0000);
      r(OFS_HOST_LINK, d);
      chk(d, 16'h0000);
      r(OFS_SCRATCH_PTR, d);
      chk(d, 16'h0000);
      r(OFS_SHARED_CODE, d);
      chk(d, 16'h0000);
      w(8'h77, 16'hffff);
      r(8'h77, d);
      chk(d, 16'h0000);
   endtask

   // Each host link bit alone drives only its own output
   task automatic t_host_link;
      w(OFS_HOST_LINK, 16'hffff);
      r(OFS_HOST_LINK, d);
      chk(d, 16'h1105);
      for (int i = 0; i < 4; i++) begin
         w(OFS_HOST_LINK, 16'h1000 >> (i == 3 ? 12 : 4 * i + (i == 2 ? 2 : 0)));
         repeat (2) @(posedge mclk);
         chk({11'h0, lvl}, 16'h0008 >> i);
      end
      w(OFS_HOST_LINK, 16'h0000);
      w(OFS_DEV_OP_SETUP, 16'h2000);
      repeat (2) @(posedge mclk);
      chk({11'h0, lvl}, 16'h0010);
      w(OFS_DEV_OP_SETUP, 16'h0000);
   endtask

   // Pointer, auto-advance across the wrap, full-word reads
   task automatic t_scratch;
      w(OFS_SCRATCH_PTR, 16'hfffe);
      r(OFS_SCRATCH_PTR, d);
      chk(d, 16'h00fe);
      w(OFS_SCRATCH_WORD, 16'h1234);
      w(OFS_SCRATCH_WORD, 16'hbeef);
      w(OFS_SCRATCH_WORD, 16'h0f0f);
      r(OFS_SCRATCH_PTR, d);
      chk(d, 16'h0001);
      w(OFS_SCRATCH_PTR, 16'h00ff);
      r(OFS_SCRATCH_WORD, d);
      chk(d, 16'hbeef);
      w(OFS_SCRATCH_PTR, 16'h0000);
      r(OFS_SCRATCH_WORD, d);
      chk(d, 16'h0f0f);
   endtask

   // Shared code to joined channels, current-mode truncation
   task automatic t_shared;
      @(posedge mclk);
      share_join <= 2'b01;
      cur_mode   <= 2'b00;
      w(OFS_SHARED_CODE, 16'habcd);
      @(posedge mclk);
      chk({4'h0, code}, 16'h0abc);
      chk({14'h0, shared_load}, 16'h0001);
      @(posedge mclk);
      chk({14'h0, shared_load}, 16'h0000);
      r(OFS_SHARED_CODE, d);
      chk(d, 16'habc0);
      share_join <= 2'b11;
      cur_mode   <= 2'b10;
      w(OFS_SHARED_CODE, 16'h5a5f);
      @(posedge mclk);
      chk({4'h0, code}, 16'h05a0);
      chk({14'h0, shared_load}, 16'h0003);
   endtask

   // Power-management form: refused while off, mapped when on
   task automatic t_pmbus;
      pw(PMB_SHARED_CODE, 16'h1110);
      r(OFS_SHARED_CODE, d);
      chk(d, 16'h5a50);
      w(OFS_HOST_LINK, 16'h0100);
      pw(PMB_SHARED_CODE, 16'h7770);
      pw(PMB_SCRATCH_PTR, 16'h0010);
      pw(PMB_SCRATCH_WORD, 16'hc3c3);
      pw(PMB_DEV_OP_SETUP, 16'h2300);
      i_dcsb_host.wr_reg(1'b1, 8'h00, PMB_SHARED_CODE, 16'h1230);
      r(OFS_SHARED_CODE, d);
      chk(d, 16'h7770);
      r(OFS_SCRATCH_PTR, d);
      chk(d, 16'h0011);
      r(OFS_DEV_OP_SETUP, d);
      chk(d, 16'h2300);
   endtask

   // Protect action for one field value, from a fresh reset
   task automatic t_protect(input logic [1:0] act);
      do_reset;
      w(OFS_DEV_OP_SETUP, {6'h00, act, 8'h00});
      @(posedge mclk);
      gpi_func <= GPI_PROTECT;
      gpio_in  <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({12'h0, prot_cmd}, 16'h0000);
      gpio_in <= 1'b1;
      gpi_en  <= 1'b1;
      @(posedge mclk);
      gpio_in <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({12'h0, prot_cmd}, 16'h0008 >> act);
      repeat (2) @(posedge mclk);
      // Slewing actions must wait for the output stage
      if (act[1])
         chk({12'h0, prot_cmd}, 16'h0000);
      slew_done <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({12'h0, prot_cmd}, 16'h0008);
   endtask

   //////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      miscompares = 0;
      n_compared  = 0;
      rst         = 1'b1;
      gpio_in     = 1'b1;
      gpi_func    = 4'h0;
      gpi_en      = 1'b0;
      slew_done   = 1'b0;
      share_join  = 2'b00;
      cur_mode    = 2'b00;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_host_link;
      t_scratch;
      t_shared;
      t_pmbus;
      for (int a = 0; a < 4; a++)
         t_protect(a[1:0]);
      print_verdict;
   end

   // Watchdog, well beyond the roughly 270 cycles the run needs
   initial begin
      #200000;
      miscompares++;
      print_verdict;
   end
endmodule
`default_nettype wire
